// ### ogpc_consts.svh
`ifndef OGPC_CONSTS_SVH
`define OGPC_CONSTS_SVH
// Functional notes
// - Pull field 14:13: 00 none, 01 pull-down, 10 pull-up, 11 reserved; reset 01.
// - Edge mode bit 12 set: interrupt on both rising and falling pin edges.
// - Edge mode 0 (reset): single edge; rising for polarity 0, falling otherwise.
// - Bit 11 picks supply: 0 digital I/O supply, 1 main power supply; reset 0.
// - Bit 10 polarity: 0 inverted active low, 1 non-inverted; reset 1.
// - Bit 9 drive style: 0 push-pull, 1 open drain; reset 0.
// - Enable bit 8 at 0 (reset) tri-states the pin; 1 is normal operation.
// - Input code 0 is debounced general input, 1 undebounced; selector 7:4 resets 0000.
// - Input codes 2..6: on/off, sleep/wake, debounced sleep/wake, sleep, power-on requests.
// - Input code 7 watchdog reset; codes 8 and 9 voltage-scaling selects 1 and 2.
// - Input codes 10,11 hardware enables; 12,13 controls; 14,15 debounced controls.
// - Output code 0 is software output; code 1 drives the 32.768kHz clock.
// - Output codes 2,3,4: on, sleep, state-change indications; 5..7 reserved.
// - Output codes 10 and 11: first and second external power enables.
// - Output code 12 system_supply_good, code 13 converter_supply_ok.
// - Output code 14 drives the 2MHz external power clock, 15 auxiliary reset.

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define OGPC_CTRL_INDEX 20'h0_781E
`define OGPC_CTRL_ADDR (`OGPC_CTRL_INDEX << 2)
`define OGPC_STAT_ADDR 20'h1_E080
`define OGPC_MASK_ADDR 20'h1_E084
`define OGPC_GPO_ADDR 20'h1_E088
`define OGPC_PIN_ADDR 20'h1_E08C
`define OGPC_CTRL_RESET 16'hA400
`define OGPC_CTRL_WMASK 16'hFFF0

// -----------------------------------------------------------------------------
// Field positions and codes
// -----------------------------------------------------------------------------
`define OGPC_DIR_BIT 15
`define OGPC_PULL_MSB 14
`define OGPC_PULL_LSB 13
`define OGPC_EDGE_MODE_BIT 12
`define OGPC_DOMAIN_BIT 11
`define OGPC_POL_BIT 10
`define OGPC_OD_BIT 9
`define OGPC_ENA_BIT 8
`define OGPC_FN_MSB 7
`define OGPC_FN_LSB 4
`define OGPC_IRQ_EDGE_BIT 0
`define OGPC_IRQ_RSVD_BIT 1
`define OGPC_PULL_DOWN 2'h1
`define OGPC_PULL_UP 2'h2
`define OGPC_FN_IN_GPIO_DEB 4'h0
`define OGPC_FN_IN_SLPWAKE_DEB 4'h4
`define OGPC_FN_IN_HWCTL1_DEB 4'hE
`define OGPC_FN_IN_HWCTL2_DEB 4'hF
`define OGPC_FN_OUT_GPO 4'h0
`define OGPC_FN_OUT_RSVD_LO 4'h5
`define OGPC_FN_OUT_RSVD_HI 4'h7

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define OGPC_CLK_PERIOD_NS 40
`define OGPC_LONG_DEB_NS 1000000
`define OGPC_LONG_DEB_CYCLES \
  ((`OGPC_LONG_DEB_NS + `OGPC_CLK_PERIOD_NS - 1) / `OGPC_CLK_PERIOD_NS)

`endif

// ### ogpc_pkg.sv
`default_nettype none

// -----------------------------------------------------------------------------
// Types shared by the pin configuration block
// -----------------------------------------------------------------------------
package ogpc_pkg;

  // Everything that leaves the block toward the pad cell travels together.
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic pull_down;
    logic main_supply;
  } ogpc_pad_t;

endpackage : ogpc_pkg

`default_nettype wire

// ### ogpc_pin_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "ogpc_consts.svh"

module ogpc_pin_config #(
  parameter int DEB_CYCLES = `OGPC_LONG_DEB_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [19:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                pin_in,
  output var ogpc_pkg::ogpc_pad_t  pad,
  input  wire logic [15:0]         out_function_src,
  output logic      [15:0]         in_function_req,
  output logic                     irq
);
  import ogpc_pkg::*;

  localparam int CW = $clog2(DEB_CYCLES + 1);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------

  // Polarity is applied the same way on the way in and on the way out.
  function automatic logic ogpc_apply_pol(input logic pol_bit, input logic v);
    return pol_bit ? v : ~v;
  endfunction : ogpc_apply_pol

  // Byte-lane merge of a 16-bit register with APB write strobes.
  function automatic logic [15:0] ogpc_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction : ogpc_merge

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [15:0]   ctrl;
  logic [1:0]    status;
  logic [1:0]    mask;
  logic          gpo;
  logic          pin_meta;
  logic          pin_sync;
  logic [CW-1:0] deb_cnt;
  logic          deb_val;
  logic          prev_raw;
  logic          dir_in;
  logic          ena;
  logic          pol;
  logic          od;
  logic          both_edges;
  logic          domain;
  logic [1:0]    pull;
  logic [3:0]    fn;
  logic          setup_ph;
  logic          wr_acc;
  logic          map_hit;
  logic [31:0]   read_mux;
  logic          use_long;
  logic          in_raw;
  logic          in_level;
  logic          in_active;
  logic          rise;
  logic          fall;
  logic          edge_evt;
  logic          out_active;
  logic          out_rsvd;
  logic          out_src;
  logic          out_level;
  logic          rsvd_evt;
  logic [1:0]    stat_clr;

  // ---------------------------------------------------------------------------
  // Control field decode
  // ---------------------------------------------------------------------------

  // Field views of the control word; the register itself is the only state.
  assign dir_in     = ctrl[`OGPC_DIR_BIT];
  assign ena        = ctrl[`OGPC_ENA_BIT];
  assign pol        = ctrl[`OGPC_POL_BIT];
  assign od         = ctrl[`OGPC_OD_BIT];
  assign both_edges = ctrl[`OGPC_EDGE_MODE_BIT];
  assign domain     = ctrl[`OGPC_DOMAIN_BIT];
  assign pull       = ctrl[`OGPC_PULL_MSB:`OGPC_PULL_LSB];
  assign fn         = ctrl[`OGPC_FN_MSB:`OGPC_FN_LSB];

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------

  // A write takes effect only on the completing access edge.
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pready & pwrite;

  // Address decode shared by reads and the error answer; writes compare paddr directly.
  always_comb begin
    map_hit  = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      `OGPC_CTRL_ADDR: read_mux = {16'h0000, ctrl};
      `OGPC_STAT_ADDR: read_mux = {30'h0000_0000, status};
      `OGPC_MASK_ADDR: read_mux = {30'h0000_0000, mask};
      `OGPC_GPO_ADDR:  read_mux = {31'h0000_0000, gpo};
      `OGPC_PIN_ADDR:  read_mux = {30'h0000_0000, pin_sync, in_level};
      default:         map_hit  = 1'b0;
    endcase
  end

  // The answer is prepared during setup so that it leaves a flip-flop; this
  // costs nothing, as the access phase then completes with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~map_hit;
      prdata  <= (setup_ph & ~pwrite) ? read_mux : 32'h0000_0000;
    end
  end

  // Control word; low nibble is not part of this block and reads zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `OGPC_CTRL_RESET;
    end else if (wr_acc && paddr == `OGPC_CTRL_ADDR) begin
      ctrl <= ogpc_merge(ctrl, pwdata[15:0], pstrb[1:0]) & `OGPC_CTRL_WMASK;
    end
  end

  // Interrupt mask and software output value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= 2'h0;
      gpo  <= 1'b0;
    end else if (wr_acc && pstrb[0]) begin
      if (paddr == `OGPC_MASK_ADDR) begin
        mask <= pwdata[1:0];
      end
      if (paddr == `OGPC_GPO_ADDR) begin
        gpo <= pwdata[0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Input path
  // ---------------------------------------------------------------------------

  // The pad is asynchronous to pclk; only the second stage is used.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Long debounce: a new level is accepted only after it held for
  // DEB_CYCLES cycles in a row; any bounce restarts the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cnt <= '0;
      deb_val <= 1'b0;
    end else if (pin_sync == deb_val) begin
      deb_cnt <= '0;
    end else if (deb_cnt == CW'(DEB_CYCLES - 1)) begin
      deb_val <= pin_sync;
      deb_cnt <= '0;
    end else begin
      deb_cnt <= deb_cnt + 1'b1;
    end
  end

  // Codes with long debounce read the filtered level, the rest the raw one.
  assign use_long  = (fn == `OGPC_FN_IN_GPIO_DEB) || (fn == `OGPC_FN_IN_SLPWAKE_DEB) ||
                     (fn == `OGPC_FN_IN_HWCTL1_DEB) || (fn == `OGPC_FN_IN_HWCTL2_DEB);
  assign in_raw    = use_long ? deb_val : pin_sync;
  assign in_level  = ogpc_apply_pol(pol, in_raw);
  assign in_active = ena & dir_in;

  // Each input code owns one bit of the request vector; only the selected
  // bit can be high, and only while the pin is an enabled input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_function_req <= 16'h0000;
    end else if (in_active && in_level) begin
      in_function_req <= 16'h0001 << fn;
    end else begin
      in_function_req <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Edge detection and interrupt
  // ---------------------------------------------------------------------------

  // Changing between debounced and raw codes can show up as one edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_raw <= 1'b0;
    end else begin
      prev_raw <= in_raw;
    end
  end

  assign rise     = in_raw & ~prev_raw;
  assign fall     = ~in_raw & prev_raw;
  assign edge_evt = in_active & (both_edges ? (rise | fall)
                                            : (pol ? fall : rise));
  assign rsvd_evt = out_active & out_rsvd;

  // Write-one-to-clear, with a new event winning over a clear.
  assign stat_clr = (wr_acc && pstrb[0] && paddr == `OGPC_STAT_ADDR) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 2'h0;
    end else begin
      status[`OGPC_IRQ_EDGE_BIT] <= edge_evt |
        (status[`OGPC_IRQ_EDGE_BIT] & ~stat_clr[`OGPC_IRQ_EDGE_BIT]);
      status[`OGPC_IRQ_RSVD_BIT] <= rsvd_evt |
        (status[`OGPC_IRQ_RSVD_BIT] & ~stat_clr[`OGPC_IRQ_RSVD_BIT]);
    end
  end

  // Level interrupt, one cycle behind the status bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ---------------------------------------------------------------------------
  // Output path
  // ---------------------------------------------------------------------------

  // Reserved output codes drive an inactive level and flag an event.
  assign out_active = ena & ~dir_in;
  assign out_rsvd   = (fn >= `OGPC_FN_OUT_RSVD_LO) && (fn <= `OGPC_FN_OUT_RSVD_HI);

  always_comb begin
    if (out_rsvd) begin
      out_src = 1'b0;
    end else if (fn == `OGPC_FN_OUT_GPO) begin
      out_src = gpo;
    end else begin
      out_src = out_function_src[fn];
    end
  end

  assign out_level = ogpc_apply_pol(pol, out_src);

  // Pad controls. Open drain only pulls low and releases for a high level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad.out         <= 1'b0;
      pad.oe_n        <= 1'b1;
      pad.pull_up     <= 1'b0;
      pad.pull_down   <= 1'b1;
      pad.main_supply <= 1'b0;
    end else begin
      pad.oe_n        <= ~out_active | (od & out_level);
      pad.out         <= out_active & ~od & out_level;
      pad.pull_up     <= (pull == `OGPC_PULL_UP);
      pad.pull_down   <= (pull == `OGPC_PULL_DOWN);
      pad.main_supply <= domain;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  chk_tristate_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ena |=> pad.oe_n && !pad.out)
    else $error("pin driven while disabled");

  chk_input_released: assert property (
    @(posedge pclk) disable iff (!presetn)
    dir_in |=> pad.oe_n)
    else $error("pin driven while set as input");

  chk_pull_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 (pad.pull_down == ($past(pull) == 2'h1)) && (pad.pull_up == ($past(pull) == 2'h2)))
    else $error("pull controls do not follow pull field");

  chk_both_edges: assert property (
    @(posedge pclk) disable iff (!presetn)
    (in_active && both_edges && (in_raw != prev_raw)) |=> status[0])
    else $error("edge event lost in both-edge mode");

  chk_single_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    (in_active && !both_edges && !status[0] && !pol && fall) |=> !status[0])
    else $error("wrong edge raised interrupt");

  chk_supply_sel: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 pad.main_supply == $past(domain))
    else $error("supply select does not follow control");

  chk_gpo_polarity: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_active && !od && fn == 4'h0) |=> pad.out == ($past(pol) ~^ $past(gpo)))
    else $error("software output polarity wrong");

  chk_open_drain: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_active && od) |=> !pad.out && (pad.oe_n == $past(out_level)))
    else $error("open drain drove high");

  chk_debounce_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(deb_val) |-> $past(pin_sync) == deb_val && $past(deb_cnt) == CW'(DEB_CYCLES - 1))
    else $error("debounced level changed early");

  chk_input_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (in_active && in_level) |=> in_function_req == (16'h0001 << $past(fn)))
    else $error("input function not routed");

  chk_input_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !in_active |=> in_function_req == 16'h0000)
    else $error("input request while pin not an input");

  chk_reserved_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_active && !od && out_rsvd) |=> pad.out == !$past(pol) ##1 status[1])
    else $error("reserved output code misbehaved");

  chk_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (status[0] && mask[0]) |=> irq)
    else $error("interrupt not raised for unmasked status");

endmodule : ogpc_pin_config

`default_nettype wire

// ### ogpc_board_model.sv
`timescale 1ns/1ns
`default_nettype none

module ogpc_board_model (
  input  wire logic                pclk,
  input  wire ogpc_pkg::ogpc_pad_t pad,
  input  wire logic                drive_en,
  input  wire logic                drive_level,
  output logic                     pin_level
);
  import ogpc_pkg::*;

  // ---------------------------------------------------------------------------
  // Board side of the pin
  // ---------------------------------------------------------------------------
  logic last_level = 1'b0;

  // The device wins while it drives, then the board, then the pulls.
  // A pin that nobody holds flips every cycle, so a floating pin is never read as a fixed level.
  always_comb begin
    if (!pad.oe_n) begin
      pin_level = pad.out;
    end else if (drive_en) begin
      pin_level = drive_level;
    end else if (pad.pull_up) begin
      pin_level = 1'b1;
    end else if (pad.pull_down) begin
      pin_level = 1'b0;
    end else begin
      pin_level = ~last_level;
    end
  end

  // Remember the wire so that a floating pin can be made to wander.
  always_ff @(posedge pclk) begin
    last_level <= pin_level;
  end

endmodule : ogpc_board_model

`default_nettype wire

// ### test_otp_gpio_pin_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "ogpc_consts.svh"

module test_otp_gpio_pin_config;
  import ogpc_pkg::*;

  // ---------------------------------------------------------------------------
  // Bench signals, design and board
  // ---------------------------------------------------------------------------
  logic        pclk             = 1'b0;
  logic        presetn          = 1'b0;
  logic        psel             = 1'b0;
  logic        penable          = 1'b0;
  logic        pwrite           = 1'b0;
  logic [19:0] paddr            = 20'h0_0000;
  logic [31:0] pwdata           = 32'h0000_0000;
  logic [15:0] out_function_src = 16'h0000;
  logic        drive_en         = 1'b0;
  logic        drive_level      = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_in;
  ogpc_pad_t   pad;
  logic [15:0] in_function_req;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          failures         = 0;
  int          check_count      = 0;
  int          cycles           = 0;

  // The debounce count is cut to 4 so the long-debounce codes settle quickly.
  ogpc_pin_config #(.DEB_CYCLES(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pad(pad), .out_function_src(out_function_src),
    .in_function_req(in_function_req), .irq(irq)
  );

  ogpc_board_model board (
    .pclk(pclk), .pad(pad), .drive_en(drive_en), .drive_level(drive_level),
    .pin_level(pin_in)
  );

  // A 40 ns period gives the 25 MHz bus clock.
  always #20 pclk = ~pclk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait has no limit of its own; a slave that never answers is caught by the timeout.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick

  function automatic logic [31:0] cw(input logic dir, input logic [1:0] pull, input logic mode,
                                     input logic pol, input logic od, input logic ena,
                                     input logic [3:0] fn);
    return {16'h0000, dir, pull, mode, 1'b0, pol, od, ena, fn, 4'h0};
  endfunction : cw

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk("pad at reset", pad, 5'h0A);
    apb(1'b0, `OGPC_CTRL_ADDR, 32'h0000_0000);
    chk("control reset", rd, 32'h0000_A400);
    apb(1'b1, `OGPC_CTRL_ADDR, 32'h0000_FFFF);
    apb(1'b0, `OGPC_CTRL_ADDR, 32'h0000_0000);
    chk("control readback", rd, 32'h0000_FFF0);
    apb(1'b0, 20'h0_0100, 32'h0000_0000);
    chk("unmapped read", {err, rd[30:0]}, 32'h8000_0000);
    $display("reset test done");
  endtask : t_reset

  task automatic t_pull();
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, `OGPC_CTRL_ADDR, cw(1'b1, p[1:0], 1'b0, 1'b1, 1'b0, 1'b0, 4'h0) | (p[0] << 11));
      tick(3);
      chk("pull", {pad.pull_up, pad.pull_down}, {p == 2, p == 1});
      chk("supply", pad.main_supply, p[0]);
      chk("disabled release", pad.oe_n, 1'b1);
    end
    $display("pull test done");
  endtask : t_pull

  // Phase bit 1 is the polarity, bit 0 says whether the chosen source is active.
  task automatic t_out();
    logic pol;
    logic exp;
    for (int ph = 0; ph < 4; ph++) begin
      pol = ph[1];
      apb(1'b1, `OGPC_GPO_ADDR, {31'h0, ph[0]});
      for (int k = 0; k < 16; k++) begin
        apb(1'b1, `OGPC_CTRL_ADDR, cw(1'b0, 2'h1, 1'b0, pol, 1'b0, 1'b1, k[3:0]));
        out_function_src <= ph[0] ? (16'h0001 << k) : ~(16'h0001 << k);
        tick(3);
        exp = (ph[0] && !(k >= 5 && k <= 7)) ? pol : ~pol;
        chk($sformatf("out code %0d", k), {pad.oe_n, pad.out}, {1'b0, exp});
        chk("out via board", pin_in, exp);
      end
    end
    // Reserved codes were selected on an enabled output, so their event bit must be set.
    apb(1'b0, `OGPC_STAT_ADDR, 32'h0000_0000);
    chk("reserved event", rd[1], 1'b1);
    apb(1'b1, `OGPC_STAT_ADDR, 32'h0000_0002);
    apb(1'b0, `OGPC_STAT_ADDR, 32'h0000_0000);
    chk("reserved cleared", rd[1], 1'b0);
    $display("output test done");
  endtask : t_out

  task automatic t_drive();
    apb(1'b1, `OGPC_CTRL_ADDR, cw(1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0));
    apb(1'b1, `OGPC_GPO_ADDR, 32'h0000_0000);
    tick(3);
    chk("od low", {pad.oe_n, pad.out}, 2'b00);
    apb(1'b1, `OGPC_GPO_ADDR, 32'h0000_0001);
    tick(3);
    chk("od high", {pad.oe_n, pad.out}, 2'b10);
    apb(1'b1, `OGPC_CTRL_ADDR, cw(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0));
    tick(3);
    chk("disabled output", pad.oe_n, 1'b1);
    apb(1'b1, `OGPC_CTRL_ADDR, cw(1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0));
    tick(3);
    chk("input released", pad.oe_n, 1'b1);
    $display("drive test done");
  endtask : t_drive

  task automatic t_in();
    logic [31:0] exp;
    for (int ph = 0; ph < 4; ph++) begin
      for (int k = 0; k < 16; k++) begin
        apb(1'b1, `OGPC_CTRL_ADDR, cw(1'b1, 2'h0, 1'b0, ph[0], 1'b0, ph[1], k[3:0]));
        drive_en <= 1'b1;
        drive_level <= ph[0];
        tick(12);
        exp = ph[1] ? (32'h0000_0001 << k) : 32'h0000_0000;
        chk($sformatf("in code %0d", k), in_function_req, exp);
        // Bit 1 is the raw synchronised pin, bit 0 the polarity-corrected level.
        apb(1'b0, `OGPC_PIN_ADDR, 32'h0000_0000);
        chk("pin state", rd, {30'h0000_0000, ph[0], 1'b1});
        drive_level <= ~ph[0];
        tick(12);
        chk("in idle", in_function_req, 32'h0000_0000);
      end
    end
    $display("input test done");
  endtask : t_in

  // The interrupt line is expected only while the edge bit is unmasked.
  task automatic edge_case(input logic mode, input logic pol, input logic lvl, input logic exp,
                           input logic irq_on = 1'b1);
    apb(1'b1, `OGPC_CTRL_ADDR, cw(1'b1, 2'h0, mode, pol, 1'b0, 1'b1, 4'h1));
    drive_level <= ~lvl;
    tick(8);
    apb(1'b1, `OGPC_STAT_ADDR, 32'h0000_0003);
    drive_level <= lvl;
    tick(8);
    apb(1'b0, `OGPC_STAT_ADDR, 32'h0000_0000);
    chk("edge status", rd[0], exp);
    chk("edge irq", irq, exp & irq_on);
  endtask : edge_case

  task automatic t_irq();
    drive_en <= 1'b1;
    apb(1'b1, `OGPC_MASK_ADDR, 32'h0000_0001);
    edge_case(1'b1, 1'b1, 1'b1, 1'b1);
    edge_case(1'b1, 1'b1, 1'b0, 1'b1);
    edge_case(1'b0, 1'b1, 1'b1, 1'b0);
    edge_case(1'b0, 1'b1, 1'b0, 1'b1);
    edge_case(1'b0, 1'b0, 1'b1, 1'b1);
    edge_case(1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, `OGPC_MASK_ADDR, 32'h0000_0000);
    edge_case(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    // Unmasking a pending edge must raise the line, and clearing it must drop it.
    apb(1'b1, `OGPC_MASK_ADDR, 32'h0000_0001);
    tick(2);
    chk("unmasked irq", irq, 1'b1);
    apb(1'b1, `OGPC_STAT_ADDR, 32'h0000_0001);
    tick(3);
    apb(1'b0, `OGPC_STAT_ADDR, 32'h0000_0000);
    chk("status cleared", {rd[0], irq}, 2'b00);
    $display("interrupt test done");
  endtask : t_irq

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // A hung handshake must not stall the run forever.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // Reset is held for 20 cycles, then each scenario runs in turn.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pull();
    t_out();
    t_drive();
    t_in();
    t_irq();
    summarize();
  end

endmodule : test_otp_gpio_pin_config

`default_nettype wire
